// File: design/gpt_pin_sync.sv
// Three-stage pin synchroniser with filtered level and rising-edge pulse.
// Assumes pins change slower than half the bus clock.
module gpt_pin_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Pins and results
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } gpt_sync_state_t;

    gpt_sync_state_t r;
    gpt_sync_state_t next_r;

    always_comb
    begin
        next_r = r;
        next_r.s1 = pin;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        for (int i = 0; i < W; i++)
        begin
            if (r.s2[i] == r.s3[i])
                next_r.lvl[i] = r.s3[i];
        end
    end

    generate
        for (genvar g = 0; g < W; g++)
        begin : g_edge
            assign rise[g] = r.s2[g] && r.s3[g] && !r.lvl[g];
        end
    endgenerate

    assign level = r.lvl;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            r <= '0;
        else
            r <= next_r;
    end

endmodule // gpt_pin_sync

// File: design/gpt_pkg.sv
// Shared constants and types of the general purpose timer.
// Assumes byte addresses on the register port and a 16-bit register width.
package gpt_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_PRESET = 32'h4000_0000;
    localparam logic [31:0] ADDR_READBACK = 32'h4000_0004;
    localparam logic [31:0] ADDR_CONTROL = 32'h4000_0008;
    localparam logic [31:0] ADDR_CLEAR = 32'h4000_000C;
    localparam logic [31:0] ADDR_SNAPSHOT = 32'h4000_0010;
    localparam logic [31:0] ADDR_FLAGS = 32'h4000_001C;

    // Values after reset and control write mask
    localparam logic [15:0] PRESET_RST = 16'h0000;
    localparam logic [15:0] CONTROL_RST = 16'h000A;
    localparam logic [15:0] CONTROL_MASK = 16'h1FFF;

    // Control fields
    localparam int CAP_ARM_BIT = 12;
    localparam int EVT_LSB = 8;
    localparam int RELOAD_BIT = 7;
    localparam int CLK_LSB = 5;
    localparam int ENABLE_BIT = 4;
    localparam int PERIODIC_BIT = 3;
    localparam int UP_BIT = 2;
    localparam int PRE_LSB = 0;

    // Clear and flag fields
    localparam int CLR_TIMEOUT_BIT = 0;
    localparam int CLR_CAPTURE_BIT = 1;
    localparam int FL_TIMEOUT_BIT = 0;
    localparam int FL_CAPTURE_BIT = 1;
    localparam int FL_BUSY_BIT = 6;
    localparam int FL_CLR_SYNC_BIT = 7;

    // Counter limits
    localparam logic [15:0] FULL_SCALE = 16'hFFFF;
    localparam logic [15:0] ZERO_SCALE = 16'h0000;

    // Prescaler divisions
    localparam logic [15:0] DIV_BUS_SRC = 16'h0004;
    localparam logic [15:0] DIV_OSC_SRC = 16'h0001;
    localparam logic [15:0] DIV_16 = 16'h0010;
    localparam logic [15:0] DIV_256 = 16'h0100;
    localparam logic [15:0] DIV_32K = 16'h8000;

    // Crossing lag of busy and clear-sync windows, in bus clock cycles
    localparam logic [1:0] XDOM_CYCLES = 2'h2;

    typedef enum logic [1:0] {SRC_PERIPH, SRC_CORE, SRC_SLOW, SRC_FAST} gpt_src_t;

endpackage

// File: design/gpt_prescale.sv
// Prescaler: divides the selected source tick into counter steps.
// Assumes src_tick is a one-cycle pulse on the bus clock.
module gpt_prescale
    import gpt_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Tick path
    gpt_tick_if.div tk
);

    typedef struct packed {
        logic [15:0] cnt;
    } gpt_div_state_t;

    gpt_div_state_t r;
    gpt_div_state_t next_r;
    logic [15:0] div;
    logic hit;

    function automatic logic [15:0] divisor(input logic [1:0] code, input gpt_src_t src);
        unique case (code)
            2'h0: divisor = (src == SRC_PERIPH || src == SRC_CORE) ? DIV_BUS_SRC
                                                                   : DIV_OSC_SRC;
            2'h1: divisor = DIV_16;
            2'h2: divisor = DIV_256;
            2'h3: divisor = DIV_32K;
        endcase
    endfunction

    assign div = divisor(tk.pre_code, tk.src);
    assign hit = r.cnt >= div - 16'h0001;
    assign tk.tick = tk.run && tk.src_tick && hit;

    always_comb
    begin
        next_r = r;
        if (!tk.run)
        begin
            next_r.cnt = 16'h0000;
        end
        else if (tk.src_tick)
        begin
            next_r.cnt = hit ? 16'h0000 : r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            r <= '0;
        else
            r <= next_r;
    end

endmodule // gpt_prescale

// File: design/gpt_tick_if.sv
// Tick path between the timer core and its prescaler.
// Assumes both ends run on the same bus clock.
interface gpt_tick_if;
    import gpt_pkg::*;
    logic src_tick;
    logic [1:0] pre_code;
    gpt_src_t src;
    logic run;
    logic tick;
    modport core (output src_tick, output pre_code, output src, output run, input tick);
    modport div (input src_tick, input pre_code, input src, input run, output tick);
endinterface

// File: design/gpt_timer.sv
// General purpose 16-bit up/down timer with preset, capture and flags.
// Assumes a single-cycle register port on the 200 MHz bus clock and
// capture events as one-cycle pulses on that clock.
module gpt_timer
    import gpt_pkg::*;
#(
    parameter int EVT_COUNT = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Clock source pins
    input wire logic core_clk_pin,
    input wire logic slow_osc_pin,
    input wire logic fast_xtal_pin,
    input wire logic fast_osc_pin,
    input wire logic clock_config_zero,
    // Capture events
    input wire logic [EVT_COUNT-1:0] capture_events,
    // Status out
    output logic timeout_irq,
    output logic capture_pending
);

    // Event select is four bits wide, so at most sixteen sources
    if (EVT_COUNT < 1 || EVT_COUNT > 16)
    begin : g_bad_count
        $error("gpt_timer: EVT_COUNT must be 1 to 16");
    end

    typedef struct packed {
        logic [15:0] preset;
        logic [15:0] pend_preset;
        logic pend_valid;
        logic [15:0] ctrl;
        logic [15:0] count;
        logic [15:0] view1;
        logic [15:0] view2;
        logic [15:0] snapshot;
        logic fl_timeout;
        logic fl_capture;
        logic [1:0] busy_cnt;
        logic [1:0] clr_cnt;
        logic en_d;
        logic [15:0] rdata;
    } gpt_state_t;

    gpt_state_t r;
    gpt_state_t next_r;

    // Pin synchronisers
    logic [4:0] pin_level;
    logic [4:0] pin_rise;

    gpt_pin_sync #(
        .W(5)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin({clock_config_zero, fast_osc_pin, fast_xtal_pin, slow_osc_pin, core_clk_pin}),
        .level(pin_level),
        .rise(pin_rise)
    );

    // Prescaler
    gpt_tick_if tk ();

    gpt_prescale u_pre (
        .clock(clock),
        .sys_rst(sys_rst),
        .tk(tk)
    );

    // Control field views
    logic enable;
    logic periodic;
    logic count_up;
    logic reload_sel;
    logic cap_arm;
    logic [3:0] evt_sel;
    gpt_src_t src;
    logic async_src;

    assign enable = r.ctrl[ENABLE_BIT];
    assign periodic = r.ctrl[PERIODIC_BIT];
    assign count_up = r.ctrl[UP_BIT];
    assign reload_sel = r.ctrl[RELOAD_BIT];
    assign cap_arm = r.ctrl[CAP_ARM_BIT];
    assign evt_sel = r.ctrl[EVT_LSB +: 4];
    assign src = gpt_src_t'(r.ctrl[CLK_LSB +: 2]);
    assign async_src = (src == SRC_SLOW) || (src == SRC_FAST);

    // Source tick selection
    always_comb
    begin
        unique case (src)
            SRC_PERIPH: tk.src_tick = 1'b1;
            SRC_CORE: tk.src_tick = pin_rise[0];
            SRC_SLOW: tk.src_tick = pin_rise[1];
            SRC_FAST: tk.src_tick = pin_level[4] ? pin_rise[2] : pin_rise[3];
        endcase
    end

    assign tk.pre_code = r.ctrl[PRE_LSB +: 2];
    assign tk.src = src;
    assign tk.run = enable && r.en_d;

    // Register port decode
    logic wr_preset;
    logic wr_control;
    logic wr_clear;

    assign wr_preset = reg_wr && reg_addr == ADDR_PRESET;
    assign wr_control = reg_wr && reg_addr == ADDR_CONTROL;
    assign wr_clear = reg_wr && reg_addr == ADDR_CLEAR;

    function automatic logic at_end(input logic [15:0] cnt, input logic up);
        at_end = up ? (cnt == FULL_SCALE) : (cnt == ZERO_SCALE);
    endfunction

    function automatic logic [15:0] start_value(input logic per, input logic up,
                                                input logic [15:0] pre);
        if (per)
            start_value = pre;
        else
            start_value = up ? ZERO_SCALE : FULL_SCALE;
    endfunction

    // Events of this cycle
    logic timeout_evt;
    logic clr_timeout;
    logic clr_capture;
    logic evt_hit;

    assign timeout_evt = tk.run && tk.tick && at_end(r.count, count_up);
    assign clr_timeout = wr_clear && reg_wdata[CLR_TIMEOUT_BIT];
    assign clr_capture = wr_clear && reg_wdata[CLR_CAPTURE_BIT];

    always_comb
    begin
        evt_hit = 1'b0;
        if (cap_arm && 32'(evt_sel) < EVT_COUNT)
            evt_hit = capture_events[evt_sel];
    end

    always_comb
    begin
        next_r = r;
        next_r.en_d = enable;

        // Preset with hold-off across a timeout
        if (r.pend_valid && !timeout_evt)
        begin
            next_r.preset = r.pend_preset;
            next_r.pend_valid = 1'b0;
        end
        if (wr_preset)
        begin
            if (timeout_evt || (r.pend_valid && timeout_evt))
            begin
                next_r.pend_preset = reg_wdata;
                next_r.pend_valid = 1'b1;
            end
            else
            begin
                next_r.preset = reg_wdata;
                next_r.pend_valid = 1'b0;
            end
        end

        // Control register
        if (wr_control)
        begin
            next_r.ctrl = reg_wdata & CONTROL_MASK;
            if (async_src || reg_wdata[CLK_LSB + 1])
                next_r.busy_cnt = XDOM_CYCLES;
        end
        else if (r.busy_cnt != 2'h0)
        begin
            next_r.busy_cnt = r.busy_cnt - 2'h1;
        end

        // Clear crossing indicator
        if (clr_timeout && async_src)
            next_r.clr_cnt = XDOM_CYCLES;
        else if (r.clr_cnt != 2'h0)
            next_r.clr_cnt = r.clr_cnt - 2'h1;

        // Up/down counter
        if (!enable)
        begin
            next_r.count = ZERO_SCALE;
        end
        else if (!r.en_d)
        begin
            next_r.count = start_value(periodic, count_up, r.preset);
        end
        else if (periodic && reload_sel && clr_timeout)
        begin
            next_r.count = r.preset;
        end
        else if (tk.tick)
        begin
            if (at_end(r.count, count_up))
                next_r.count = start_value(periodic, count_up, r.preset);
            else if (count_up)
                next_r.count = r.count + 16'h0001;
            else
                next_r.count = r.count - 16'h0001;
        end

        // Timeout flag, set wins over clear
        if (clr_timeout)
            next_r.fl_timeout = 1'b0;
        if (timeout_evt)
            next_r.fl_timeout = 1'b1;

        // Capture flag and snapshot lock
        if (clr_capture)
            next_r.fl_capture = 1'b0;
        if (evt_hit && (!r.fl_capture || clr_capture))
        begin
            next_r.snapshot = r.count;
            next_r.fl_capture = 1'b1;
        end

        // Readback lag
        next_r.view1 = r.count;
        next_r.view2 = r.view1;

        // Read data
        next_r.rdata = 16'h0000;
        if (reg_rd)
        begin
            unique case (reg_addr)
                ADDR_PRESET: next_r.rdata = r.preset;
                ADDR_READBACK: next_r.rdata = r.view2;
                ADDR_CONTROL: next_r.rdata = r.ctrl;
                ADDR_SNAPSHOT: next_r.rdata = r.snapshot;
                ADDR_FLAGS:
                begin
                    next_r.rdata[FL_TIMEOUT_BIT] = r.fl_timeout;
                    next_r.rdata[FL_CAPTURE_BIT] = r.fl_capture;
                    next_r.rdata[FL_BUSY_BIT] = r.busy_cnt != 2'h0;
                    next_r.rdata[FL_CLR_SYNC_BIT] = r.clr_cnt != 2'h0;
                end
                default: next_r.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r <= '0;
            r.preset <= PRESET_RST;
            r.ctrl <= CONTROL_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign timeout_irq = r.fl_timeout;
    assign capture_pending = r.fl_capture;

endmodule // gpt_timer

// File: sim/gpt_timer_sva.sv
// Port checker of the general purpose timer.
// Assumes the top module's ports only; bound in below its endmodule.
module gpt_timer_sva
    import gpt_pkg::*;
#(
    parameter int EVT_COUNT = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Events and status
    input wire logic [EVT_COUNT-1:0] capture_events,
    input wire logic timeout_irq,
    input wire logic capture_pending
);
    logic [15:0] ctrl;
    logic [2:0] idle;

    // Shadow of control and cycles spent disabled
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl <= CONTROL_RST;
            idle <= 3'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == ADDR_CONTROL)
                ctrl <= reg_wdata & CONTROL_MASK;
            idle <= ctrl[ENABLE_BIT] ? 3'h0 : ((idle == 3'h7) ? idle : idle + 3'h1);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_rd(a);
        $past(reg_rd) && $past(reg_addr) == a;
    endsequence
    sequence s_clr(b);
        reg_wr && reg_addr == ADDR_CLEAR && reg_wdata[b];
    endsequence

    chk_ctrl_value: assert property (s_rd(ADDR_CONTROL) |-> reg_rdata == $past(ctrl))
        else $error("control read differs from written value");
    chk_ctrl_rsvd: assert property (s_rd(ADDR_CONTROL) |-> reg_rdata[15:13] == 3'h0)
        else $error("reserved control bits not zero");
    chk_flag_mirror: assert property (s_rd(ADDR_FLAGS) |->
        reg_rdata[1:0] == {$past(capture_pending), $past(timeout_irq)})
        else $error("flag read differs from status outputs");
    chk_zero_idle: assert property (reg_rd && reg_addr == ADDR_READBACK && idle >= 3'h4
        |=> reg_rdata == 16'h0000)
        else $error("readback not zero while disabled");
    chk_tmo_clear: assert property (s_clr(CLR_TIMEOUT_BIT) ##0 idle >= 3'h4
        |-> ##[1:3] !timeout_irq)
        else $error("timeout flag survived its clear");
    chk_irq_enabled: assert property ($rose(timeout_irq) |-> $past(idle) < 3'h3)
        else $error("timeout raised while disabled");
    chk_tmo_hold: assert property (timeout_irq && !reg_wr && !$past(reg_wr) |=> timeout_irq)
        else $error("timeout flag dropped without clear");
    chk_pend_hold: assert property (capture_pending && !reg_wr && !$past(reg_wr)
        |=> capture_pending)
        else $error("capture pending dropped without clear");
    chk_pend_clear: assert property (s_clr(CLR_CAPTURE_BIT) ##0 capture_events == '0
        ##0 $past(capture_events) == '0 |-> ##[1:2] !capture_pending)
        else $error("capture pending survived its clear");
    chk_pend_cause: assert property ($rose(capture_pending) |->
        ($past(capture_events) != '0 || $past(capture_events, 2) != '0) &&
        ($past(ctrl[CAP_ARM_BIT]) || $past(ctrl[CAP_ARM_BIT], 2)))
        else $error("capture pending without armed event");
endmodule // gpt_timer_sva

bind gpt_timer gpt_timer_sva #(.EVT_COUNT(EVT_COUNT)) u_sva (
    .clock(clock),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .capture_events(capture_events),
    .timeout_irq(timeout_irq),
    .capture_pending(capture_pending)
);

// File: sim/gpt_timer_tb.sv
// Self-checking bench of the general purpose timer.
// Assumes the port checker is bound in from its own file.
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module gpt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpt_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] reg_addr = 32'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] pins = 4'h0;
    logic cfg0 = 1'b0;
    logic [15:0] evts = 16'h0;
    logic [15:0] reg_rdata;
    logic timeout_irq;
    logic capture_pending;
    logic rd_seen = 1'b0;
    logic [31:0] lfsr = 32'hCA3EA234;
    logic [15:0] eq[$];
    logic [15:0] mq[$];
    string nq[$];
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [3:0] s;
    logic [31:0] ra[7] = '{ADDR_PRESET, ADDR_READBACK, ADDR_CONTROL, ADDR_CLEAR,
        ADDR_SNAPSHOT, ADDR_FLAGS, 32'h4000_0020};
    logic [15:0] re[7] = '{16'h0, 16'h0, CONTROL_RST, 16'h0, 16'h0, 16'h0, 16'h0};
    // Free-run bus source runs: control, wait, expected count, mask
    logic [15:0] bc[5] = '{16'h0014, 16'h0015, 16'h0016, 16'h0017, 16'h0010};
    int bw[5] = '{38, 440, 5000, 2000, 38};
    logic [15:0] be[5] = '{16'h0008, 16'h0018, 16'h0010, 16'h0000, 16'hFFF0};
    logic [15:0] bm[5] = '{16'hFFF8, 16'hFFF8, 16'hFFF8, 16'hFFFF, 16'hFFF8};

    always #2.5 clock = ~clock;

    gpt_timer uut (
        .clock(clock),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .core_clk_pin(pins[0]),
        .slow_osc_pin(pins[1]),
        .fast_xtal_pin(pins[2]),
        .fast_osc_pin(pins[3]),
        .clock_config_zero(cfg0),
        .capture_events(evts),
        .timeout_irq(timeout_irq),
        .capture_pending(capture_pending)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    // Notes the expected value, the watcher compares it
    task automatic rd(input logic [31:0] a, input logic [15:0] e, input logic [15:0] m,
        input string nm);
        eq.push_back(e & m);
        mq.push_back(m);
        nq.push_back(nm);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
    endtask

    // Selected pin gives n/2 rising edges, the others n
    task automatic toggle(input int sel, input int n);
        repeat (n)
        begin
            pins <= ~pins;
            cyc(4);
            pins <= pins ^ ~(4'h1 << sel);
            cyc(4);
        end
    endtask

    task automatic pulse(input logic [3:0] b);
        evts <= 16'h1 << b;
        @(posedge clock);
        evts <= 16'h0;
        cyc(3);
    endtask

    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clock)
        rd_seen <= reg_rd;

    always @(negedge clock)
    begin
        if (rd_seen && eq.size() > 0)
        begin
            `CHK(nq[0], eq[0], reg_rdata & mq[0])
            void'(eq.pop_front());
            void'(mq.pop_front());
            void'(nq.pop_front());
        end
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            bad_count++;
            close_out();
        end
    end

    initial
    begin
        cyc(20);
        sys_rst <= 1'b0;
        cyc(1);
        for (int i = 0; i < 7; i++)
            rd(ra[i], re[i], 16'hFFFF, "reset value");
        wr(ADDR_CONTROL, 16'hFFEF);
        rd(ADDR_CONTROL, 16'h1FEF, 16'hFFFF, "control");
        wr(ADDR_READBACK, 16'hFFFF);
        rd(ADDR_READBACK, 16'h0000, 16'hFFFF, "readback write");
        for (int i = 0; i < 5; i++)
        begin
            wr(ADDR_CONTROL, bc[i]);
            cyc(bw[i]);
            rd(ADDR_READBACK, be[i], bm[i], "bus count");
            wr(ADDR_CONTROL, 16'h0000);
            cyc(4);
            rd(ADDR_READBACK, 16'h0000, 16'hFFFF, "disabled count");
        end
        for (int i = 0; i < 4; i++)
        begin
            cfg0 <= (i == 2);
            wr(ADDR_CONTROL, 16'h0014 | (((i == 0) ? 16'h1 : ((i == 1) ? 16'h2 : 16'h3)) << 5));
            rd(ADDR_FLAGS, (i == 0) ? 16'h0000 : 16'h0040, 16'h0040, "busy");
            cyc(4);
            toggle(i, 16);
            cyc(8);
            rd(ADDR_READBACK, (i == 0) ? 16'h2 : 16'h8, 16'hFFFF, "pin count");
            wr(ADDR_CONTROL, 16'h0000);
            cyc(4);
        end
        wr(ADDR_PRESET, 16'h1002);
        wr(ADDR_CONTROL, 16'h0098);
        cyc(4);
        rd(ADDR_READBACK, 16'h1000, 16'hFFF0, "periodic start");
        cyc(40);
        rd(ADDR_READBACK, 16'h0F00, 16'hFF00, "periodic down");
        wr(ADDR_CLEAR, 16'h0001);
        cyc(4);
        rd(ADDR_READBACK, 16'h1000, 16'hFFF0, "reload on clear");
        wr(ADDR_CONTROL, 16'h0000);
        wr(ADDR_PRESET, 16'h0002);
        wr(ADDR_CONTROL, 16'h0018);
        cyc(30);
        rd(ADDR_FLAGS, 16'h0001, 16'h0001, "timeout flag");
        `CHK("timeout irq", 1'b1, timeout_irq)
        wr(ADDR_CONTROL, 16'h0000);
        cyc(4);
        wr(ADDR_CLEAR, 16'h0001);
        rd(ADDR_FLAGS, 16'h0000, 16'h0001, "timeout cleared");
        `CHK("timeout irq cleared", 1'b0, timeout_irq)
        repeat (2)
        begin
            lfsr = lfsr_next(lfsr);
            s = lfsr[3:0];
            wr(ADDR_CONTROL, 16'h1014 | (16'(s) << 8));
            cyc(30);
            pulse(s ^ 4'h1);
            rd(ADDR_FLAGS, 16'h0000, 16'h0002, "other event");
            pulse(s);
            rd(ADDR_FLAGS, 16'h0002, 16'h0002, "capture flag");
            `CHK("capture pending", 1'b1, capture_pending)
            rd(ADDR_SNAPSHOT, 16'h0008, 16'hFFF8, "snapshot");
            cyc(200);
            pulse(s);
            rd(ADDR_SNAPSHOT, 16'h0008, 16'hFFF8, "snapshot locked");
            wr(ADDR_CLEAR, 16'h0002);
            rd(ADDR_FLAGS, 16'h0000, 16'h0002, "capture cleared");
            `CHK("pending cleared", 1'b0, capture_pending)
            wr(ADDR_CONTROL, 16'h0014 | (16'(s) << 8));
            pulse(s);
            rd(ADDR_FLAGS, 16'h0000, 16'h0002, "capture disarmed");
            wr(ADDR_CONTROL, 16'h0000);
            wr(ADDR_CLEAR, 16'h0003);
        end
        cyc(4);
        close_out();
    end
endmodule // gpt_timer_tb
